//--- verilog/fspl_top.sv
// Purpose: Sector write protection logic with Wishbone register access
// Assumes: 25 MHz clk_i, synchronous active-high rst_i as power-on reset
// Notes: Hardware reset pin is synchronised before use
// Notes: Register writes and commands act on the edge that takes the request
// Notes on behaviour
// RULE1 - Freeze latch is configuration bit zero
// RULE2 - Freeze holds block-protect and top/bottom bits
// RULE3 - Freeze cleared only by power-on reset
// RULE4 - Freeze zero lets protect bits be written
// RULE5 - Freeze one refuses one-time area programming
// RULE6 - Frozen protect-bit writes ignored, no error
// RULE7 - Sector protected by range OR per-sector
// RULE8 - Either per-sector bit zero blocks sector
// RULE9 - Lock zero refuses nonvolatile bit changes
// RULE10 - Persistent mode: lock set at reset, clear-only
// RULE11 - Password mode: lock cleared, set on match
// RULE12 - Mode bits: 11 default, 10 persistent, 01 password
// RULE13 - Programming both mode bits zero fails
// RULE14 - New part: persistent mode, all unprotected
// RULE15 - Selected mode freezes mode register
// RULE16 - Host programs password before mode bits
// RULE17 - Write-in-progress set during mode programming
// RULE18 - Nonvolatile bits programmed singly, erased together
// RULE19 - Erase preprogram internal, status stays readable
// RULE20 - Volatile bit matters only if nonvolatile one
// RULE21 - Volatile bit writable either way, unlimited
// RULE22 - Locked nonvolatile ops fail unchanged; bits readable
// RULE23 - Wrong password fails, error set, busy stays
// RULE24 - Software reset keeps lock unchanged
// RULE25 - Array ops checked at acceptance, rejected whole
//
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`include "fspl_defines.svh"

module fspl_top
	import fspl_pkg::*;
(
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Power-on reset
	input wire logic hw_rst_n_i, // Hardware reset pin, async
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Bus strobe
	input wire logic wb_we_i, // Write
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte lanes
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	output logic [15:0] prot_map_o, // Effective protection per sector
	output logic busy_o // Write in progress
);
	// ****************************************************
	// Storage
	// ****************************************************
	logic hwr_meta_ff; // Sync stage one
	logic hwr_sync_ff; // Sync stage two, active low
	logic hwr_prev_ff; // Previous synced level
	logic [2:0] bp_ff; // Block-protect bits
	logic tb_ff; // Top/bottom select
	logic freeze_ff; // Freeze latch
	logic perr_ff; // Program error
	logic eerr_ff; // Erase error
	logic [15:0] nvb_ff; // Nonvolatile sector bits
	logic [15:0] vb_ff; // Volatile sector bits
	logic lock_ff; // Nonvolatile bit lock
	logic [1:0] mode_ff; // One-time mode bits
	logic [63:0] pwd_ff; // Hidden password
	logic [63:0] pwd_in_ff; // Staged password value
	logic [7:0] cnt_ff; // Busy countdown
	fspl_state_e state_ff; // Sequencer state
	logic [31:0] rdat_ff; // Read data
	logic ack_ff; // Ack
	logic [15:0] prot_ff; // Protection map out
	logic busy_ff; // Write in progress, registered for the pin

	// ****************************************************
	// Decoding
	// ****************************************************
	// Mask of protected sectors from block-protect code, lower end when tb is set, upper end when clear
	function automatic logic [15:0] bp_mask(input logic [2:0] bp, input logic tb);
		logic [4:0] n;
		logic [15:0] m;
		logic [15:0] rv; // Mirrored mask
		n = (bp == 3'h0) ? 5'h00 : (bp < 3'h4) ? 5'h01 : 5'(5'h01 << (bp - 3'h3));
		m = 16'((17'h00001 << n) - 17'h00001);
		rv = {<<{m}}; // Bit reversal gives the upper-end mask
		return tb ? m : rv;
	endfunction

	// Byte-lane merge of a 32-bit word
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Requests are taken on the edge that sees cyc and stb without ack
	wire logic req = wb_cyc_i & wb_stb_i & ~ack_ff; // New bus request
	wire logic wr = req & wb_we_i; // Write request
	wire logic wr_cmd = wr & (wb_adr_i == `FSPL_ADR_CMD); // Command write
	wire logic wr_reg = wr & (wb_adr_i == `FSPL_ADR_WRREG); // Write-registers
	wire logic hw_reset = hwr_prev_ff & ~hwr_sync_ff; // Reset pin fell
	wire fspl_cmd_s cmd = fspl_cmd_s'({wb_dat_i[`FSPL_CMD_MODE_LSB +: 2],
		wb_dat_i[`FSPL_CMD_VAL], wb_dat_i[`FSPL_CMD_SEC_LSB +: 4],
		wb_dat_i[`FSPL_CMD_OP_LSB +: 4]}); // Command fields from their word positions
	wire logic idle = (state_ff == FSPL_ST_IDLE); // Ready for commands
	wire logic go = wr_cmd & idle; // Command accepted
	wire logic fail_go = wr_cmd & (state_ff == FSPL_ST_FAIL); // Recovery commands
	wire logic [15:0] sec_bit = 16'h0001 << cmd.sector; // Target sector
	wire logic pwd_mode = (mode_ff == 2'h1); // Password management
	wire logic [15:0] blk_prot = bp_mask(bp_ff, tb_ff); // Range protection
	wire logic [15:0] scheme_prot = ~(nvb_ff & vb_ff); // Per-sector [RULE8] [RULE20]
	wire logic [15:0] prot = blk_prot | scheme_prot; // Combined [RULE7]
	wire logic sec_prot = |(prot & sec_bit); // Target protected
	wire logic pwd_match = (pwd_in_ff == pwd_ff); // Exact 64-bit compare [RULE11]
	wire logic is_op_nvb = go & ((cmd.op == FSPL_OP_NVB_PROG) | (cmd.op == FSPL_OP_NVB_ERASE));
	wire logic nvb_ok = is_op_nvb & lock_ff; // Lock gates nonvolatile bits [RULE9]
	wire logic mode_ok = (mode_ff == `FSPL_MODE_RST) & (cmd.mode != 2'h0); // [RULE13] [RULE15]
	wire logic sw_reset = (go | fail_go) & (cmd.op == FSPL_OP_SW_RESET); // Soft reset
	wire logic clr_err = (go | fail_go) & (cmd.op == FSPL_OP_CLR_ERR) | sw_reset;

	// Operation outcome: error flags and busy length
	logic op_perr; // Program-class failure
	logic op_eerr; // Erase-class failure
	logic op_stick; // Stay busy after fail
	logic [7:0] op_len; // Busy cycles
	always_comb begin
		op_perr = 1'b0;
		op_eerr = 1'b0;
		op_stick = 1'b0;
		op_len = `FSPL_PROG_CYCLES;
		unique case (cmd.op)
			FSPL_OP_NVB_PROG: op_perr = ~lock_ff; // [RULE22]
			FSPL_OP_NVB_ERASE: begin
				op_eerr = ~lock_ff; // [RULE22]
				op_len = `FSPL_ERASE_CYCLES; // Internal preprogram and verify [RULE19]
			end
			FSPL_OP_MODE_PROG: op_perr = ~mode_ok; // [RULE13] [RULE15]
			FSPL_OP_PWD_PROG: op_perr = (mode_ff != `FSPL_MODE_RST);
			FSPL_OP_OTP_PROG: op_perr = freeze_ff; // [RULE5]
			FSPL_OP_ARR_PROG: op_perr = sec_prot; // [RULE25]
			FSPL_OP_ARR_ERASE: begin
				op_eerr = sec_prot; // [RULE25]
				op_len = `FSPL_ERASE_CYCLES;
			end
			FSPL_OP_PWD_UNLOCK: begin
				op_perr = ~pwd_match | ~pwd_mode;
				op_stick = ~pwd_match | ~pwd_mode; // Busy stays set [RULE23]
			end
			default: op_len = 8'h01; // Volatile and register commands
		endcase
	end

	// ****************************************************
	// Reset pin synchroniser
	// ****************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hwr_meta_ff <= 1'b1;
			hwr_sync_ff <= 1'b1;
			hwr_prev_ff <= 1'b1;
		end else begin
			hwr_meta_ff <= hw_rst_n_i;
			hwr_sync_ff <= hwr_meta_ff;
			hwr_prev_ff <= hwr_sync_ff;
		end
	end

	// ****************************************************
	// Freeze latch and block-protect bits
	// ****************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			freeze_ff <= 1'b0; // Only power-on clears it [RULE3]
			bp_ff <= 3'h0; // Fresh part unprotected [RULE14]
			tb_ff <= 1'b0;
		end else if (wr_reg & idle & wb_sel_i[0] & wb_sel_i[1]) begin
			freeze_ff <= freeze_ff | wb_dat_i[8 + `FSPL_CFG_FREEZE]; // Set only [RULE1] [RULE3]
			if (!freeze_ff) begin // Writable while clear [RULE4]
				bp_ff <= wb_dat_i[`FSPL_SR_BP_LSB +: 3];
				tb_ff <= wb_dat_i[8 + `FSPL_CFG_TB];
			end // Frozen: silently kept, no error [RULE2] [RULE6]
		end
	end

	// ****************************************************
	// Nonvolatile state: sector bits, mode bits, password
	// ****************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nvb_ff <= 16'hffff; // [RULE14]
			mode_ff <= `FSPL_MODE_RST; // Persistent by default [RULE12] [RULE14]
			pwd_ff <= `FSPL_PWD_RST;
		end else if (go) begin
			if (nvb_ok & (cmd.op == FSPL_OP_NVB_PROG)) begin
				nvb_ff <= nvb_ff & ~sec_bit; // One bit to zero [RULE18]
			end
			if (nvb_ok & (cmd.op == FSPL_OP_NVB_ERASE)) begin
				nvb_ff <= 16'hffff; // Whole group to one [RULE18]
			end
			if ((cmd.op == FSPL_OP_MODE_PROG) & mode_ok) begin
				mode_ff <= cmd.mode; // One-time selection [RULE12]
			end
			if ((cmd.op == FSPL_OP_PWD_PROG) & (mode_ff == `FSPL_MODE_RST)) begin
				pwd_ff <= pwd_ff & pwd_in_ff; // Only zeros program
			end
		end
	end

	// ****************************************************
	// Volatile bits and the lock
	// ****************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i | hw_reset) begin
			vb_ff <= 16'hffff;
			lock_ff <= ~pwd_mode; // [RULE10] [RULE11]
		end else if (sw_reset) begin
			vb_ff <= 16'hffff; // Lock kept as is [RULE24]
		end else if (go) begin
			if (cmd.op == FSPL_OP_VB_WRITE) begin
				vb_ff <= cmd.val ? (vb_ff | sec_bit) : (vb_ff & ~sec_bit); // [RULE21]
			end
			if (cmd.op == FSPL_OP_LOCK_CLR) begin
				lock_ff <= 1'b0; // Set back by a reset outside password mode or by a password match in password mode [RULE10]
			end
			if ((cmd.op == FSPL_OP_PWD_UNLOCK) & pwd_mode & pwd_match) begin
				lock_ff <= 1'b1; // Exact match only [RULE11]
			end
		end
	end

	// ****************************************************
	// Sequencer and error flags
	// ****************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i | hw_reset) begin
			state_ff <= FSPL_ST_IDLE;
			busy_ff <= 1'b0;
			cnt_ff <= 8'h00;
			perr_ff <= 1'b0;
			eerr_ff <= 1'b0;
		end else if (clr_err) begin
			state_ff <= FSPL_ST_IDLE;
			busy_ff <= 1'b0; // Recovery clears busy
			perr_ff <= 1'b0;
			eerr_ff <= 1'b0;
		end else if (go) begin
			state_ff <= op_stick ? FSPL_ST_FAIL : FSPL_ST_BUSY; // [RULE17] [RULE23]
			busy_ff <= 1'b1; // Busy from acceptance [RULE17]
			cnt_ff <= op_len;
			perr_ff <= perr_ff | op_perr;
			eerr_ff <= eerr_ff | op_eerr;
		end else if (state_ff == FSPL_ST_BUSY) begin
			cnt_ff <= cnt_ff - 8'h01;
			if (cnt_ff == 8'h01) begin
				state_ff <= FSPL_ST_IDLE;
				busy_ff <= 1'b0; // Last busy cycle
			end
		end
	end

	// ****************************************************
	// Password staging, writable by software
	// ****************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwd_in_ff <= 64'h0;
		end else if (wr & (wb_adr_i == `FSPL_ADR_PWD_LO)) begin
			pwd_in_ff[31:0] <= lane_merge(pwd_in_ff[31:0], wb_dat_i, wb_sel_i);
		end else if (wr & (wb_adr_i == `FSPL_ADR_PWD_HI)) begin
			pwd_in_ff[63:32] <= lane_merge(pwd_in_ff[63:32], wb_dat_i, wb_sel_i);
		end
	end

	// ****************************************************
	// Bus read path and outputs
	// ****************************************************
	wire logic write_in_progress_flag = (state_ff != FSPL_ST_IDLE); // Busy flag
	wire logic [7:0] sr1 = {1'b0, perr_ff, eerr_ff, bp_ff, 1'b0, write_in_progress_flag};
	wire logic [7:0] cfg = {2'h0, tb_ff, 4'h0, freeze_ff};
	logic [31:0] rmux; // Read selection
	always_comb begin
		unique case (wb_adr_i)
			`FSPL_ADR_STATUS: rmux = {16'h0, cfg, sr1}; // Readable while busy [RULE19]
			`FSPL_ADR_PWD_LO: rmux = pwd_in_ff[31:0];
			`FSPL_ADR_PWD_HI: rmux = pwd_in_ff[63:32];
			`FSPL_ADR_NVB: rmux = {16'h0, nvb_ff}; // Per-sector readback [RULE22]
			`FSPL_ADR_VB: rmux = {16'h0, vb_ff};
			`FSPL_ADR_PROT: rmux = {16'h0, prot};
			`FSPL_ADR_MODE: rmux = {23'h0, lock_ff, 5'h0, mode_ff, 1'b1};
			default: rmux = 32'h0; // Unmapped and write-only read zero
		endcase
	end

	// Single-wait-state ack and registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h0;
			prot_ff <= 16'h0;
		end else begin
			ack_ff <= req;
			rdat_ff <= req ? rmux : 32'h0;
			prot_ff <= prot; // [RULE7]
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign prot_map_o = prot_ff;
	assign busy_o = busy_ff;

	// ****************************************************
	// Checks
	// ****************************************************
	freeze_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
		freeze_ff |=> freeze_ff) else $error("freeze latch cleared");
	bp_frozen_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
		freeze_ff |=> $stable(bp_ff) && $stable(tb_ff)) else $error("frozen bits moved");
	frozen_noerr_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
		(wr_reg && idle && freeze_ff && !perr_ff) |=> !perr_ff) else $error("frozen write erred");
	otp_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
		(go && cmd.op == FSPL_OP_OTP_PROG && freeze_ff) |=> perr_ff) else $error("otp not refused");
	prot_map_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
		##1 prot_map_o == $past(bp_mask(bp_ff, tb_ff) | ~(nvb_ff & vb_ff)))
		else $error("protection map wrong");
	nvb_locked_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
		(is_op_nvb && !lock_ff) |=> $stable(nvb_ff) && (perr_ff || eerr_ff))
		else $error("locked bits changed");
	lock_noset_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
		(!pwd_mode && !lock_ff && !hw_reset) |=> !lock_ff) else $error("lock set by command");
	mode_once_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE15]
		(mode_ff != 2'h3) |=> $stable(mode_ff)) else $error("mode changed after selection");
	mode_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
		(go && cmd.op == FSPL_OP_MODE_PROG && cmd.mode == 2'h0) |=> perr_ff && mode_ff != 2'h0)
		else $error("zero mode accepted");
	mode_busy_a: assert property (@(posedge clk_i) disable iff (rst_i || hw_reset) // [RULE17]
		(go && cmd.op == FSPL_OP_MODE_PROG) |=> busy_o [*8]) else $error("busy dropped early");
	pwd_fail_a: assert property (@(posedge clk_i) disable iff (rst_i || hw_reset) // [RULE23]
		(go && cmd.op == FSPL_OP_PWD_UNLOCK && !pwd_match && !clr_err) |=> perr_ff && busy_o)
		else $error("bad password not failed");
	swr_lock_a: assert property (@(posedge clk_i) disable iff (rst_i || hw_reset) // [RULE24]
		sw_reset |=> $stable(lock_ff)) else $error("soft reset moved lock");
	// Checks on the effect of a register write and of some accepted commands, one cycle later; busy flag checked every cycle
	bp_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
		(wr_reg && idle && wb_sel_i[1:0] == 2'h3 && !freeze_ff)
		|=> bp_ff == $past(wb_dat_i[`FSPL_SR_BP_LSB +: 3])) else $error("open bits not written");
	nvb_single_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE18]
		(nvb_ok && cmd.op == FSPL_OP_NVB_PROG)
		|=> (nvb_ff ^ $past(nvb_ff)) == ($past(nvb_ff) & $past(sec_bit)))
		else $error("sector bit program wrong");
	nvb_erase_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE18]
		(nvb_ok && cmd.op == FSPL_OP_NVB_ERASE) |=> nvb_ff == 16'hffff)
		else $error("sector bits not erased");
	vb_write_a: assert property (@(posedge clk_i) disable iff (rst_i || hw_reset) // [RULE21]
		(go && cmd.op == FSPL_OP_VB_WRITE) |=> vb_ff[$past(cmd.sector)] == $past(cmd.val))
		else $error("volatile bit write lost");
	lock_clear_a: assert property (@(posedge clk_i) disable iff (rst_i || hw_reset) // [RULE10]
		(go && cmd.op == FSPL_OP_LOCK_CLR) |=> !lock_ff) else $error("lock not cleared");
	pwd_unlock_a: assert property (@(posedge clk_i) disable iff (rst_i || hw_reset) // [RULE11]
		(go && cmd.op == FSPL_OP_PWD_UNLOCK && pwd_mode && pwd_match) |=> lock_ff)
		else $error("good password refused");
	pwd_closed_a: assert property (@(posedge clk_i) disable iff (rst_i || hw_reset) // [RULE15]
		(go && cmd.op == FSPL_OP_PWD_PROG && mode_ff != 2'h3) |=> $stable(pwd_ff) && perr_ff)
		else $error("password changed after mode");
	busy_state_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE17]
		busy_o == (state_ff != FSPL_ST_IDLE) && $onehot(state_ff))
		else $error("busy flag out of step");
endmodule

//--- verilog/fspl_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the sector protection block
// Assumes: Included by the top module and by the bench files
// Notes: Definitions only
`ifndef FSPL_DEFINES_SVH
`define FSPL_DEFINES_SVH

// ****************************************************
// Register byte offsets
// ****************************************************
`define FSPL_ADR_STATUS 8'h00
`define FSPL_ADR_WRREG 8'h04
`define FSPL_ADR_CMD 8'h08
`define FSPL_ADR_PWD_LO 8'h0c
`define FSPL_ADR_PWD_HI 8'h10
`define FSPL_ADR_NVB 8'h14
`define FSPL_ADR_VB 8'h18
`define FSPL_ADR_PROT 8'h1c
`define FSPL_ADR_MODE 8'h20

// ****************************************************
// Field positions
// ****************************************************
`define FSPL_SR_BUSY 0
`define FSPL_SR_BP_LSB 2
`define FSPL_SR_EERR 5
`define FSPL_SR_PERR 6
`define FSPL_CFG_FREEZE 0
`define FSPL_CFG_TB 5
`define FSPL_CMD_OP_LSB 0
`define FSPL_CMD_SEC_LSB 8
`define FSPL_CMD_VAL 16
`define FSPL_CMD_MODE_LSB 17
`define FSPL_MODE_LOCK 8

// ****************************************************
// Reset values and counts
// ****************************************************
`define FSPL_NSEC 16
`define FSPL_MODE_RST 2'h3
`define FSPL_PWD_RST 64'hffff_ffff_ffff_ffff
`define FSPL_PROG_CYCLES 8'h08
`define FSPL_ERASE_CYCLES 8'h20

`endif

//--- verilog/fspl_pkg.sv
// Purpose: Types shared by the sector protection block
// Assumes: Defines header present
// Notes: Commands arrive as a packed struct decoded from a bus word
package fspl_pkg;
	// ****************************************************
	// Command opcodes
	// ****************************************************
	typedef enum logic [3:0] {
		FSPL_OP_NVB_PROG = 4'h1,
		FSPL_OP_NVB_ERASE = 4'h2,
		FSPL_OP_VB_WRITE = 4'h3,
		FSPL_OP_LOCK_CLR = 4'h4,
		FSPL_OP_PWD_UNLOCK = 4'h5,
		FSPL_OP_MODE_PROG = 4'h6,
		FSPL_OP_PWD_PROG = 4'h7,
		FSPL_OP_OTP_PROG = 4'h8,
		FSPL_OP_ARR_PROG = 4'h9,
		FSPL_OP_ARR_ERASE = 4'ha,
		FSPL_OP_SW_RESET = 4'hb,
		FSPL_OP_CLR_ERR = 4'hc
	} fspl_op_e;

	// Decoded command word
	typedef struct packed {
		logic [1:0] mode;
		logic val;
		logic [3:0] sector;
		logic [3:0] op;
	} fspl_cmd_s;

	// Sequencer states, one-hot
	typedef enum logic [2:0] {
		FSPL_ST_IDLE = 3'b001,
		FSPL_ST_BUSY = 3'b010,
		FSPL_ST_FAIL = 3'b100
	} fspl_state_e;
endpackage

//--- tb/fspl_host.sv
// Purpose: Host model that issues protection commands over the bus
// Assumes: Classic single-cycle bus, one request at a time
// Notes: hung is set when an answer or completion never comes
`timescale 1ns/1ps
`include "fspl_defines.svh"

module fspl_host (
	input wire logic clk_i, // System clock
	input wire logic busy_i, // Write in progress
	input wire logic wb_ack_i, // Acknowledge
	input wire logic [31:0] wb_dat_i, // Read data
	output logic wb_cyc_o, // Bus cycle
	output logic wb_stb_o, // Strobe
	output logic wb_we_o, // Write
	output logic [7:0] wb_adr_o, // Address
	output logic [3:0] wb_sel_o, // Byte lanes
	output logic [31:0] wb_dat_o // Write data
);
	bit hung = 1'b0; // No answer seen

	// Bus idle at time zero
	initial begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o = 1'b0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'hf;
		wb_dat_o = 32'h0;
	end

	// ****************************************************
	// Bus cycles
	// ****************************************************
	// One transfer, held until ack is sampled
	task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		@(posedge clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= w;
		wb_adr_o <= a;
		wb_dat_o <= d;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack_i !== 1'b1 && i < 50);
		if (wb_ack_i !== 1'b1) hung = 1'b1;
		q = wb_dat_i;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0, q);
	endtask

	// Command word: op, sector, value, mode bits
	task automatic issue(input int op, input int s, input int v, input int md);
		wr(`FSPL_ADR_CMD, 32'(md << 17 | v << 16 | s << 8 | op));
	endtask

	// Poll write-in-progress until idle
	task automatic idle(output bit seen);
		int i;
		seen = busy_i;
		for (i = 0; i < 200 && busy_i !== 1'b0; i++) @(posedge clk_i);
		if (busy_i !== 1'b0) hung = 1'b1;
	endtask

	// Password first, mode bits after
	task automatic pwd_mode(output bit seen);
		bit b;
		issue(7, 0, 0, 0);
		idle(b);
		issue(6, 0, 0, 1);
		idle(seen);
	endtask
endmodule

//--- tb/fspl_test.sv
// Purpose: Self-checking bench for the sector protection block
// Assumes: Host model drives the bus
// Notes: Integer model tracks all protection state
`timescale 1ns/1ps
`include "fspl_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end

module fspl_test
	import fspl_pkg::*;
;
	logic clk_i = 1'b0; // Clock
	logic rst_i = 1'b1; // Power-on reset
	logic hw_rst_n = 1'b1; // Hardware reset pin
	logic cyc, stb, we, ack, busy; // Bus and status
	logic [7:0] adr; // Address
	logic [3:0] sel; // Lanes
	logic [31:0] wdat, rdat, q; // Data
	logic [15:0] pmap; // Protection map
	logic [15:0] m_nvb, m_vb; // Model bits
	logic [63:0] m_pwd, stg; // Model password, staged value
	logic [31:0] seed = 32'h0000bedc; // Random state
	int n_errors = 0;
	int comparisons = 0;
	int m_bp, m_tb, m_frz, m_perr, m_eerr, m_lock, m_mode; // Model state
	bit b; // Busy seen

	always #20 clk_i = ~clk_i;

	fspl_top uut (.clk_i(clk_i), .rst_i(rst_i), .hw_rst_n_i(hw_rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .prot_map_o(pmap), .busy_o(busy));

	fspl_host u_host (.clk_i(clk_i), .busy_i(busy), .wb_ack_i(ack), .wb_dat_i(rdat),
		.wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
		.wb_dat_o(wdat));

	// ****************************************************
	// Helpers
	// ****************************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Range OR per-sector bits
	function automatic logic [31:0] exp_prot();
		int n;
		logic [15:0] r;
		n = m_bp == 0 ? 0 : m_bp < 4 ? 1 : 1 << (m_bp - 3);
		r = 16'((32'h1 << n) - 1);
		if (m_tb == 0) r = 16'(r << (16 - n));
		return {16'h0, r | ~m_nvb | ~m_vb};
	endfunction

	task automatic results();
		if (n_errors == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic hang_chk();
		if (u_host.hung) begin
			n_errors++;
			results();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.wr(a, d);
		hang_chk();
	endtask

	task automatic rd(input logic [7:0] a);
		u_host.rd(a, q);
		hang_chk();
	endtask

	// Compare status, sector-bit, mode and protection registers with the model
	task automatic chk(input int busy_exp);
		rd(`FSPL_ADR_STATUS);
		`CHK(q, 32'(m_tb << 13 | m_frz << 8 | m_perr << 6 | m_eerr << 5 | m_bp << 2 | busy_exp))
		rd(`FSPL_ADR_NVB);
		`CHK(q, {16'h0, m_nvb})
		rd(`FSPL_ADR_VB);
		`CHK(q, {16'h0, m_vb})
		rd(`FSPL_ADR_MODE);
		`CHK(q, 32'(m_lock << 8 | m_mode << 1 | 1))
		rd(`FSPL_ADR_PROT);
		`CHK(q, exp_prot())
		`CHK({16'h0, pmap}, exp_prot())
	endtask

	// Command plus model update
	task automatic cmd(input int op, input int s, input int v, input int md, input bit wt);
		logic [31:0] p;
		p = exp_prot();
		u_host.issue(op, s, v, md);
		case (op)
			1: if (m_lock != 0) m_nvb[s] = 1'b0; else m_perr = 1;
			2: if (m_lock != 0) m_nvb = 16'hffff; else m_eerr = 1;
			3: m_vb[s] = v[0];
			4: m_lock = 0;
			5: if (m_mode == 1 && stg === m_pwd) m_lock = 1; else m_perr = 1;
			6: if (m_mode != 3 || md == 0) m_perr = 1; else m_mode = md;
			7: if (m_mode != 3) m_perr = 1; else m_pwd = m_pwd & stg;
			8: if (m_frz != 0) m_perr = 1;
			9: if (p[s]) m_perr = 1;
			10: if (p[s]) m_eerr = 1;
			11: begin
				m_vb = 16'hffff;
				m_perr = 0;
				m_eerr = 0;
			end
			default: begin
				m_perr = 0;
				m_eerr = 0;
			end
		endcase
		if (wt) u_host.idle(b);
		hang_chk();
	endtask

	task automatic wrreg(input int bp, input int tb, input int fz);
		wr(`FSPL_ADR_WRREG, 32'(tb << 13 | fz << 8 | bp << 2));
		if (m_frz == 0) begin
			m_bp = bp;
			m_tb = tb;
		end
		if (fz != 0) m_frz = 1;
	endtask

	task automatic stage(input logic [63:0] v);
		wr(`FSPL_ADR_PWD_LO, v[31:0]);
		wr(`FSPL_ADR_PWD_HI, v[63:32]);
		stg = v;
	endtask

	task automatic hwrst();
		hw_rst_n <= 1'b0;
		repeat (4) @(posedge clk_i);
		hw_rst_n <= 1'b1;
		repeat (8) @(posedge clk_i);
		m_vb = 16'hffff;
		m_lock = m_mode != 1;
		m_perr = 0;
		m_eerr = 0;
	endtask

	task automatic por();
		rst_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		{m_bp, m_tb, m_frz, m_perr, m_eerr} = '0;
		m_lock = 1;
		m_mode = 3;
		m_nvb = 16'hffff;
		m_vb = 16'hffff;
		m_pwd = '1;
	endtask

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		por();
		chk(0);
		wrreg(5, 1, 0);
		for (int i = 0; i < 8; i++) cmd(3, int'(rnd() & 32'hf), int'(rnd() & 32'h1), 0, 1);
		cmd(1, 12, 0, 0, 1);
		chk(0);
		for (int s = 0; s < 16; s++) begin
			cmd(9, s, 0, 0, 1);
			chk(0);
			cmd(12, 0, 0, 0, 1);
		end
		cmd(10, 0, 0, 0, 1);
		chk(0);
		cmd(2, 0, 0, 0, 0);
		rd(`FSPL_ADR_STATUS);
		`CHK(q[0], 1'b1)
		u_host.idle(b);
		chk(0);
		cmd(4, 0, 0, 0, 1);
		cmd(1, 3, 0, 0, 1);
		chk(0);
		cmd(11, 0, 0, 0, 1);
		chk(0);
		hwrst();
		chk(0);
		wrreg(2, 0, 0);
		wrreg(2, 0, 1);
		wrreg(7, 1, 0);
		cmd(8, 0, 0, 0, 1);
		chk(0);
		hwrst();
		cmd(6, 0, 0, 0, 1);
		chk(0);
		cmd(12, 0, 0, 0, 1);
		stage({rnd(), rnd()});
		u_host.pwd_mode(b);
		hang_chk();
		`CHK(b, 1'b1)
		m_pwd = stg;
		m_mode = 1;
		hwrst();
		chk(0);
		cmd(6, 0, 0, 2, 1);
		cmd(7, 0, 0, 0, 1);
		chk(0);
		cmd(12, 0, 0, 0, 1);
		stage(m_pwd ^ 64'h1);
		cmd(5, 0, 0, 0, 0);
		repeat (40) @(posedge clk_i);
		chk(1);
		cmd(12, 0, 0, 0, 1);
		stage(m_pwd);
		cmd(5, 0, 0, 0, 1);
		cmd(1, 5, 0, 0, 1);
		chk(0);
		por();
		chk(0);
		results();
	end
endmodule
